// File: dtr_consts.vh
// Constants for the dual-tone receiver decode and steering block
`ifndef DTR_CONSTS_VH
`define DTR_CONSTS_VH

`define DTR_ADDR_W 12
`define DTR_CTRL_OFS 12'h000
`define DTR_CODE_OFS 12'h004
`define DTR_ISTAT_OFS 12'h008
`define DTR_IMASK_OFS 12'h00c

`define DTR_PWDN_BIT 0
`define DTR_INH_BIT 1
`define DTR_DV_BIT 2
`define DTR_CTRL_RST 3'h1

`define DTR_INT_W 2
`define DTR_INT_TONE_BIT 0
`define DTR_INT_END_BIT 1
`define DTR_IMASK_RST 2'h0

`define DTR_SYNC_STAGES 2

`define DTR_CODE_D 4'h0
`define DTR_CODE_ZERO 4'ha
`define DTR_CODE_STAR 4'hb
`define DTR_CODE_HASH 4'hc
`define DTR_CODE_A 4'hd
`define DTR_CODE_RST 4'h0

`endif

// File: dtr_sync.v
// Two-stage level synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "dtr_consts.vh"

module dtr_sync (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // Level in and out
   input wire level_in,
   output reg level_out
);

   reg meta_reg;

   // First stage feeds only the second
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= 1'b0;
         level_out <= 1'b0;
      end else begin
         meta_reg <= level_in;
         level_out <= meta_reg;
      end
   end

endmodule // dtr_sync
`default_nettype wire

// File: dtr_encoder.v
// Tone pair to 4-bit code encoder
`timescale 1ns/100ps
`default_nettype none
`include "dtr_consts.vh"

module dtr_encoder (
   // Detector levels, one-hot, bit 0 the lowest tone
   input wire [3:0] low_in,
   input wire [3:0] high_in,
   input wire inhibit_in,
   // Result
   output reg [3:0] code_out,
   output reg pair_ok_out
);

   reg [1:0] row;
   reg [1:0] col;
   reg low_one;
   reg high_one;

   always @* begin
      row = 2'd0;
      col = 2'd0;
      low_one = 1'b1;
      high_one = 1'b1;
      case (low_in)
         4'h1: row = 2'd0;
         4'h2: row = 2'd1;
         4'h4: row = 2'd2;
         4'h8: row = 2'd3;
         default: low_one = 1'b0;
      endcase
      case (high_in)
         4'h1: col = 2'd0;
         4'h2: col = 2'd1;
         4'h4: col = 2'd2;
         4'h8: col = 2'd3;
         default: high_one = 1'b0;
      endcase
      // Twin tones or silence in a group are not a pair
      pair_ok_out = low_one & high_one &
         ~(inhibit_in & (col == 2'd3));
      code_out = `DTR_CODE_D;
      if (col == 2'd3) begin
         code_out = (row == 2'd3) ? `DTR_CODE_D :
            (`DTR_CODE_A + {2'b00, row});
      end else if (row == 2'd3) begin
         case (col)
            2'd0: code_out = `DTR_CODE_STAR;
            2'd1: code_out = `DTR_CODE_ZERO;
            default: code_out = `DTR_CODE_HASH;
         endcase
      end else begin
         code_out = {row, 2'b00} - {2'b00, row} + {2'b00, col} +
            4'h1;
      end
   end

endmodule // dtr_encoder
`default_nettype wire

// File: dtr_top.v
// Dual-tone receiver decode, steering handshake and APB registers
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "dtr_consts.vh"

module dtr_top (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,

   // APB slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [`DTR_ADDR_W-1:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,

   // Zero-crossing detector levels, one-hot per group
   input wire [3:0] low_group_in,
   input wire [3:0] high_group_in,

   // Steering network
   input wire steering_sense_in,
   output reg steering_drive_out,

   // Decoded tone
   output reg [3:0] tone_code_out,
   output reg valid_out,

   // Interrupt
   output reg irq_out
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_LATCH = 3'b010;
   localparam [2:0] ST_VALID = 3'b100;
   // Control reset word, so one bit of it can be picked at its own width
   localparam [2:0] CTRL_RST = `DTR_CTRL_RST;

   // Control register fields
   reg rx_power_down_reg;
   reg letter_tone_inhibit_reg;
   reg tone_valid_flag_reg;
   reg tone_valid_flag_next;

   // Interrupt status and mask
   reg [`DTR_INT_W-1:0] int_stat_reg;
   reg [`DTR_INT_W-1:0] int_stat_next;
   reg [`DTR_INT_W-1:0] int_mask_reg;

   // Steering sequence
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [3:0] cand_code_reg;
   reg cand_ok_reg;
   reg [3:0] tone_code_next;
   reg valid_next;
   reg drive_next;
   reg ev_tone;
   reg ev_end;

   // Decoder and synchroniser results
   wire [3:0] pair_code;
   wire pair_ok;
   wire sense_sync;

   // Bus decode
   wire setup_ph;
   wire access_wr;
   reg [31:0] rd_mux;
   reg addr_hit;
   wire wr_ctrl;
   wire wr_istat;
   wire wr_imask;

   dtr_encoder u_enc (
      .low_in(low_group_in),
      .high_in(high_group_in),
      .inhibit_in(letter_tone_inhibit_reg),
      .code_out(pair_code),
      .pair_ok_out(pair_ok)
   );

   dtr_sync u_sense_sync (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .level_in(steering_sense_in),
      .level_out(sense_sync)
   );

   // APB: one wait-free access phase, pready raised from the setup cycle
   assign setup_ph = psel_in & ~penable_in;
   assign access_wr = psel_in & penable_in & pready_out & pwrite_in;
   assign wr_ctrl = access_wr & (paddr_in == `DTR_CTRL_OFS);
   assign wr_istat = access_wr & (paddr_in == `DTR_ISTAT_OFS);
   assign wr_imask = access_wr & (paddr_in == `DTR_IMASK_OFS);

   always @* begin
      rd_mux = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr_in)
         `DTR_CTRL_OFS: begin
            // Upper control bits always read back as zero
            rd_mux[`DTR_PWDN_BIT] = rx_power_down_reg;
            rd_mux[`DTR_INH_BIT] = letter_tone_inhibit_reg;
            rd_mux[`DTR_DV_BIT] = tone_valid_flag_reg;
         end
         `DTR_CODE_OFS: begin
            rd_mux[3:0] = tone_code_out;
         end
         `DTR_ISTAT_OFS: begin
            rd_mux[`DTR_INT_W-1:0] = int_stat_reg;
         end
         `DTR_IMASK_OFS: begin
            rd_mux[`DTR_INT_W-1:0] = int_mask_reg;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= setup_ph;
         pslverr_out <= setup_ph & ~addr_hit;
         if (setup_ph & ~pwrite_in) begin
            prdata_out <= rd_mux;
         end else if (~psel_in) begin
            prdata_out <= 32'h0000_0000;
         end
      end
   end

   // Control and interrupt mask registers: control bits above 2 have no storage
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_power_down_reg <= CTRL_RST[`DTR_PWDN_BIT];
         letter_tone_inhibit_reg <= 1'b0;
         int_mask_reg <= `DTR_IMASK_RST;
      end else begin
         if (wr_ctrl) begin
            rx_power_down_reg <= pwdata_in[`DTR_PWDN_BIT];
            letter_tone_inhibit_reg <= pwdata_in[`DTR_INH_BIT];
         end
         if (wr_imask) begin
            int_mask_reg <= pwdata_in[`DTR_INT_W-1:0];
         end
      end
   end

   // Steering sequence: drive follows the detected pair, sense decides
   always @* begin
      state_next = state_reg;
      tone_code_next = tone_code_out;
      valid_next = valid_out;
      ev_tone = 1'b0;
      ev_end = 1'b0;
      drive_next = pair_ok & ~rx_power_down_reg;
      case (state_reg)
         ST_IDLE: begin
            valid_next = 1'b0;
            if (sense_sync & cand_ok_reg & ~rx_power_down_reg) begin
               // Code goes out first, valid one cycle later
               tone_code_next = cand_code_reg;
               state_next = ST_LATCH;
            end
         end
         ST_LATCH: begin
            valid_next = 1'b1;
            ev_tone = ~rx_power_down_reg;
            state_next = ST_VALID;
         end
         ST_VALID: begin
            if (~sense_sync | rx_power_down_reg) begin
               valid_next = 1'b0;
               ev_end = ~rx_power_down_reg;
               state_next = ST_IDLE;
            end
         end
         default: begin
            valid_next = 1'b0;
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         steering_drive_out <= 1'b0;
         tone_code_out <= `DTR_CODE_RST;
         valid_out <= 1'b0;
         cand_code_reg <= `DTR_CODE_RST;
         cand_ok_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         steering_drive_out <= drive_next;
         tone_code_out <= tone_code_next;
         valid_out <= valid_next;
         // Remember the last pair that charged the network
         if (drive_next) begin
            cand_code_reg <= pair_code;
            cand_ok_reg <= 1'b1;
         end else if (state_reg == ST_LATCH) begin
            cand_ok_reg <= 1'b0;
         end
      end
   end

   // Flags: a hardware set wins over a software clear in the same cycle
   always @* begin
      tone_valid_flag_next = tone_valid_flag_reg;
      if (wr_ctrl) begin
         tone_valid_flag_next = pwdata_in[`DTR_DV_BIT];
      end
      if (ev_tone) begin
         tone_valid_flag_next = 1'b1;
      end
      int_stat_next = int_stat_reg;
      if (wr_istat) begin
         int_stat_next = int_stat_reg & ~pwdata_in[`DTR_INT_W-1:0];
      end
      if (ev_tone) begin
         int_stat_next[`DTR_INT_TONE_BIT] = 1'b1;
      end
      if (ev_end) begin
         int_stat_next[`DTR_INT_END_BIT] = 1'b1;
      end
   end

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tone_valid_flag_reg <= 1'b0;
         int_stat_reg <= {`DTR_INT_W{1'b0}};
         irq_out <= 1'b0;
      end else begin
         tone_valid_flag_reg <= tone_valid_flag_next;
         int_stat_reg <= int_stat_next;
         irq_out <= |(int_stat_next & int_mask_reg);
      end
   end

endmodule // dtr_top
`default_nettype wire

// File: dtr_top_chk_asserts.sv
// Port-level assertions for the tone receiver top
`timescale 1ns/100ps
`default_nettype none
`include "dtr_consts.vh"
module dtr_top_chk (
   // Clock, reset and APB
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [`DTR_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   // Tone side
   input wire logic [3:0] low_group_in,
   input wire logic steering_sense_in,
   input wire logic steering_drive_out,
   input wire logic [3:0] tone_code_out,
   input wire logic valid_out,
   input wire logic irq_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // Two sync flops plus the valid register
   sequence s_sense_gone;
      !steering_sense_in [*4];
   endsequence
   a_code_then_valid: assert property (
      $changed(tone_code_out) |=> $rose(valid_out)) else $error("valid late");
   a_valid_synced: assert property (
      $rose(valid_out) |-> $past(steering_sense_in, 4)) else $error("no sync");
   a_valid_drop: assert property (
      s_sense_gone |=> !valid_out) else $error("valid stuck");
   a_code_holds: assert property (
      valid_out |=> $stable(tone_code_out)) else $error("code moved");
   a_drive_needs_pair: assert property (
      low_group_in == 4'h0 |=> !steering_drive_out) else $error("drive idle");
   a_irq_on_event: assert property (
      $rose(irq_out) |-> $rose(valid_out) || $fell(valid_out))
      else $error("stray irq");
   a_ready_pulse: assert property (
      psel_in && !penable_in |=> pready_out ##1 !pready_out)
      else $error("ready pulse");
   a_ctrl_upper_zero: assert property (
      pready_out && !pwrite_in && paddr_in == `DTR_CTRL_OFS
      |-> prdata_out[31:3] == 29'h0) else $error("upper bits");
endmodule // dtr_top_chk

bind dtr_top dtr_top_chk u_chk (.*);
`default_nettype wire

// File: dtr_rc_model.sv
// Behavioural model of the external RC steering network
`timescale 1ns/100ps
`default_nettype none
module dtr_rc_model #(
   parameter int FULL = 8,
   parameter int TRIP = 4
) (
   // Clock and pins
   input wire logic sys_clk_in,
   input wire logic drive_in,
   output logic sense_out
);
   int level = 0;
   // Node charges while driven, drains through the resistor otherwise
   always @(posedge sys_clk_in) begin
      if (drive_in && level < FULL) begin
         level <= level + 1;
      end else if (!drive_in && level > 0) begin
         level <= level - 1;
      end
   end
   assign sense_out = (level > TRIP);
endmodule // dtr_rc_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the tone receiver top
`timescale 1ns/100ps
`default_nettype none
`include "dtr_consts.vh"
module tb_top;
   logic sys_clk_in = 1'h0;
   logic rst_in = 1'h1;
   logic psel_in = 1'h0;
   logic penable_in = 1'h0;
   logic pwrite_in = 1'h0;
   logic [11:0] paddr_in = 12'h0;
   logic [31:0] pwdata_in = 32'h0;
   logic [3:0] low_group_in = 4'h0;
   logic [3:0] high_group_in = 4'h0;
   logic [31:0] prdata_out, rd;
   logic [3:0] tone_code_out;
   logic pready_out, pslverr_out, steering_sense_in;
   logic steering_drive_out, valid_out, irq_out, err;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   dtr_top u_dut (.*);
   dtr_rc_model u_rc (
      .sys_clk_in(sys_clk_in),
      .drive_in(steering_drive_out),
      .sense_out(steering_sense_in)
   );

   initial begin
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   task automatic print_verdict();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One idle cycle after each transfer keeps drivers single per step
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'h1;
      @(posedge sys_clk_in);
      while (pready_out !== 1'h1) begin
         @(posedge sys_clk_in);
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
      @(posedge sys_clk_in);
   endtask

   task automatic wait_valid(input logic lvl);
      int n;
      n = 0;
      while (valid_out !== lvl && n < 40) begin
         n++;
         @(posedge sys_clk_in);
      end
      chk("valid", {31'h0, lvl}, {31'h0, valid_out});
   endtask

   task automatic reg_scenario();
      apb(1'h0, `DTR_CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h1, rd);
      apb(1'h0, `DTR_IMASK_OFS, 32'h0);
      chk("mask reset", 32'h0, rd);
      apb(1'h1, `DTR_CTRL_OFS, 32'hff);
      apb(1'h0, `DTR_CTRL_OFS, 32'h0);
      chk("ctrl rw", 32'h7, rd);
      apb(1'h0, 12'h010, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'h1, `DTR_CTRL_OFS, 32'h0);
      apb(1'h1, `DTR_IMASK_OFS, 32'h3);
   endtask

   task automatic digit_scenario();
      logic [63:0] tab;
      tab = 64'h0cab_f987_e654_d321;
      for (int i = 0; i < 16; i++) begin
         low_group_in <= 4'h1 << i[3:2];
         high_group_in <= 4'h1 << i[1:0];
         wait_valid(1'h1);
         chk("code", {28'h0, tab[i*4 +: 4]}, {28'h0, tone_code_out});
         chk("irq", 32'h1, {31'h0, irq_out});
         chk("drive", 32'h1, {31'h0, steering_drive_out});
         low_group_in <= 4'h0;
         high_group_in <= 4'h0;
         wait_valid(1'h0);
         chk("held", {28'h0, tab[i*4 +: 4]}, {28'h0, tone_code_out});
         apb(1'h0, `DTR_CODE_OFS, 32'h0);
         chk("code reg", {28'h0, tab[i*4 +: 4]}, rd);
         apb(1'h0, `DTR_ISTAT_OFS, 32'h0);
         chk("istat", 32'h3, rd);
         apb(1'h0, `DTR_CTRL_OFS, 32'h0);
         apb(1'h0, `DTR_CTRL_OFS, 32'h0);
         chk("dv flag", 32'h4, rd);
         apb(1'h1, `DTR_ISTAT_OFS, 32'h3);
         apb(1'h1, `DTR_CTRL_OFS, 32'h0);
         chk("irq clear", 32'h0, {31'h0, irq_out});
      end
   endtask

   task automatic blocked(input logic [31:0] ctl, input logic [3:0] lo,
                          input logic [3:0] hi);
      apb(1'h1, `DTR_CTRL_OFS, ctl);
      low_group_in <= lo;
      high_group_in <= hi;
      repeat (20) @(posedge sys_clk_in);
      chk("no drive", 32'h0, {31'h0, steering_drive_out});
      chk("no valid", 32'h0, {31'h0, valid_out});
      apb(1'h0, `DTR_CTRL_OFS, 32'h0);
      chk("no flag", ctl, rd);
      chk("no irq", 32'h0, {31'h0, irq_out});
      low_group_in <= 4'h0;
      high_group_in <= 4'h0;
   endtask

   initial begin
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      @(posedge sys_clk_in);
      reg_scenario();
      digit_scenario();
      blocked(32'h2, 4'h1, 4'h8);
      blocked(32'h1, 4'h2, 4'h2);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
